//--- core/arith_pkg.sv
package arith_pkg;
  // ==========================================================
  // opcode groups (upper nibble) and low-nibble operand forms
  localparam logic [3:0] GRP_INC = 4'h0;
  localparam logic [3:0] GRP_DEC = 4'h1;
  localparam logic [3:0] GRP_ADD = 4'h2;
  localparam logic [3:0] GRP_SUM_WITH_CARRY_TO_ACC = 4'h3;
  localparam logic [3:0] GRP_MINUS_WITH_BORROW = 4'h9;
  localparam logic [3:0] LO_ACC_IMM = 4'h4;
  localparam logic [3:0] LO_DIR = 4'h5;
  localparam logic [7:0] OP_INC_DATA_POINTER = 8'hA3;
  localparam logic [7:0] OP_MUL = 8'hA4;
  localparam logic [7:0] OP_DIV = 8'h84;
  localparam logic [7:0] OP_DAA = 8'hD4;
  localparam logic [7:0] OP_MOVC_DATA_POINTER = 8'h93;
  localparam logic [7:0] OP_CPL_BIT = 8'hB2;
  // ==========================================================
  // internal special function register addresses
  localparam logic [7:0] SFR_ACC = 8'hE0;
  localparam logic [7:0] SFR_B = 8'hF0;
  localparam logic [7:0] SFR_PSW = 8'hD0;
  localparam logic [7:0] SFR_DPL = 8'h82;
  localparam logic [7:0] SFR_DPH = 8'h83;
  localparam logic [3:0] BIT_RAM_HI = 4'h2;
  // ==========================================================
  // status word fields and reset values
  localparam int PSW_CY = 7;
  localparam int PSW_AC = 6;
  localparam int PSW_RS1 = 4;
  localparam int PSW_RS0 = 3;
  localparam int PSW_OV = 2;
  localparam logic [7:0] PSW_RST = 8'h00;
  localparam logic [15:0] PC_RST = 16'h0000;
  // ==========================================================
  // cycle counts per instruction form
  localparam logic [2:0] CYC_1 = 3'h1;
  localparam logic [2:0] CYC_ALU_MEM = 3'h2;
  localparam logic [2:0] CYC_RN_INCDEC = 3'h2;
  localparam logic [2:0] CYC_MEM_INCDEC = 3'h3;
  localparam logic [2:0] CYC_MUL = 3'h2;
  localparam logic [2:0] CYC_DIV = 3'h6;
  localparam logic [2:0] CYC_DAA = 3'h3;
  localparam logic [2:0] CYC_MOVC = 3'h5;
  localparam logic [2:0] CYC_CPL_BIT = 3'h3;
endpackage : arith_pkg

//--- core/arith_core.sv
`timescale 1ns/1ps
// Functional notes
// [RULE1] direct form uses 8-bit address byte
// [RULE2] indirect via bank pointer zero/one or data_pointer; the code's indirect forms use only bank registers 0/1
// [RULE3] bank_register chosen by opcode low bits
// [RULE4] indexed read: data_pointer plus accumulator, code only
// [RULE5] bit operand from 256-bit space
// [RULE6] accumulator-only forms carry no specifier
// [RULE7] immediate operand taken from instruction byte
// [RULE8] one to few cycles per instruction
// [RULE9] arithmetic accepts five operand forms; the code decodes four (register, indirect, direct, immediate)
// [RULE10] add bytes and cycles per form
// [RULE11] add with carry, same timing as add
// [RULE12] minus_with_borrow timing per form
// [RULE13] increment/minus_one_op timing, pointer increment
// [RULE14] product_op: acc times b, two cycles
// [RULE15] divide six cycles, bcd_fixup_op three cycles
// [RULE16] add and subtract update carry
// [RULE17] status word bits select bank
module arith_core (
  input wire logic clk,
  input wire logic srst,
  output logic [15:0] code_addr,
  input wire logic [7:0] code_byte0,
  input wire logic [7:0] code_byte1,
  output logic [15:0] table_addr,
  input wire logic [7:0] table_data,
  output logic [7:0] ram_addr,
  output logic ram_sfr,
  output logic ram_re,
  output logic ram_we,
  output logic [7:0] ram_wdata,
  input wire logic [7:0] ram_rdata,
  output logic [7:0] acc_out,
  output logic [7:0] psw_out,
  output logic insn_done
);
  // ==========================================================
  // architectural state
  logic [7:0] acc_reg, acc_next, b_reg, b_next, psw_reg, psw_next;
  logic [15:0] data_pointer_reg, data_pointer_next, pc_reg;
  logic [2:0] cnt_reg;
  logic [7:0] bank_reg [32];
  logic [15:0] table_addr_reg;
  logic [7:0] ram_addr_reg, ram_wdata_reg;
  logic ram_sfr_reg, ram_re_reg, ram_we_reg, done_reg;
  // ==========================================================
  // decode of the opcode byte
  wire [7:0] op = code_byte0;
  wire [3:0] hi = op[7:4];
  wire [3:0] lo = op[3:0];
  wire is_rn = lo[3];
  wire is_ind = lo[3:1] == 3'h3;
  wire is_dir = lo == arith_pkg::LO_DIR;
  wire is_acc_imm = lo == arith_pkg::LO_ACC_IMM;
  wire any_form = is_rn | is_ind | is_dir | is_acc_imm;
  wire is_sub = hi == arith_pkg::GRP_MINUS_WITH_BORROW;
  wire alu_op = any_form & (hi == arith_pkg::GRP_ADD | hi == arith_pkg::GRP_SUM_WITH_CARRY_TO_ACC | is_sub); // RULE9
  wire is_dec = hi == arith_pkg::GRP_DEC;
  wire id_op = any_form & (hi == arith_pkg::GRP_INC | is_dec);
  wire is_mul = op == arith_pkg::OP_MUL;
  wire is_div = op == arith_pkg::OP_DIV;
  wire is_daa = op == arith_pkg::OP_DAA;
  wire is_incdptr = op == arith_pkg::OP_INC_DATA_POINTER;
  wire is_movc = op == arith_pkg::OP_MOVC_DATA_POINTER;
  wire is_cplbit = op == arith_pkg::OP_CPL_BIT;
  wire mem_op = ((alu_op | id_op) & (is_dir | is_ind)) | is_cplbit;
  wire rmw = (id_op & (is_dir | is_ind)) | is_cplbit;
  // cycle count and length per form; unknown opcodes retire as 1-byte 1-cycle
  wire [2:0] ncyc = is_div ? arith_pkg::CYC_DIV : is_movc ? arith_pkg::CYC_MOVC : // RULE15
    is_daa ? arith_pkg::CYC_DAA : is_mul ? arith_pkg::CYC_MUL : // RULE14
    is_cplbit ? arith_pkg::CYC_CPL_BIT :
    (id_op & (is_dir | is_ind)) ? arith_pkg::CYC_MEM_INCDEC : // RULE13
    (id_op & is_rn) ? arith_pkg::CYC_RN_INCDEC :
    (alu_op & !is_rn) ? arith_pkg::CYC_ALU_MEM : arith_pkg::CYC_1; // RULE10 RULE11 RULE12 RULE8
  wire [15:0] nlen = (((alu_op | id_op) & is_dir) | (alu_op & is_acc_imm) | is_cplbit)
    ? 16'h0002 : 16'h0001;
  wire start = cnt_reg == 3'h0;
  wire last = cnt_reg == ncyc - 3'h1;
  // ==========================================================
  // operand location: bank select from status word
  wire [4:0] rn_idx = {psw_reg[arith_pkg::PSW_RS1:arith_pkg::PSW_RS0], op[2:0]}; // RULE17 RULE3
  wire [4:0] ri_idx = {psw_reg[arith_pkg::PSW_RS1:arith_pkg::PSW_RS0], 2'h0, op[0]}; // RULE2
  wire [7:0] rn_val = bank_reg[rn_idx];
  wire [7:0] ri_val = bank_reg[ri_idx];
  // bits 00-7F map onto the bit RAM bytes, 80-FF onto special function bytes
  wire [7:0] bit_byte = code_byte1[7] ? {code_byte1[7:3], 3'h0}
    : {arith_pkg::BIT_RAM_HI, code_byte1[6:3]}; // RULE5
  wire [7:0] tgt = is_cplbit ? bit_byte : is_dir ? code_byte1 : ri_val; // RULE1 RULE2
  // only direct and bit forms reach SPECIAL_FUNCTION_REGISTERS space; indirect high goes to RAM
  wire tgt_sfr = (is_dir | is_cplbit) & tgt[7]; // RULE1
  wire tgt_bank = !tgt_sfr & (tgt[7:5] == 3'h0);
  wire hit_acc = tgt_sfr & (tgt == arith_pkg::SFR_ACC);
  wire hit_b = tgt_sfr & (tgt == arith_pkg::SFR_B);
  wire hit_psw = tgt_sfr & (tgt == arith_pkg::SFR_PSW);
  wire hit_dpl = tgt_sfr & (tgt == arith_pkg::SFR_DPL);
  wire hit_dph = tgt_sfr & (tgt == arith_pkg::SFR_DPH);
  wire tgt_int = tgt_bank | hit_acc | hit_b | hit_psw | hit_dpl | hit_dph;
  wire [7:0] int_val = tgt_bank ? bank_reg[tgt[4:0]] : hit_acc ? acc_reg : hit_b ? b_reg :
    hit_psw ? psw_reg : hit_dpl ? data_pointer_reg[7:0] : data_pointer_reg[15:8];
  wire [7:0] src_mem = tgt_int ? int_val : ram_rdata;
  wire [7:0] alu_src = is_rn ? rn_val : is_acc_imm ? code_byte1 : src_mem; // RULE7
  // ==========================================================
  // adder / subtractor with carry-in from status word
  wire cy = psw_reg[arith_pkg::PSW_CY];
  wire cin = (hi == arith_pkg::GRP_SUM_WITH_CARRY_TO_ACC | is_sub) & cy; // RULE11 RULE12
  wire [8:0] sum9 = {1'b0, acc_reg} + {1'b0, alu_src} + {8'h00, cin};
  wire [4:0] sumn = {1'b0, acc_reg[3:0]} + {1'b0, alu_src[3:0]} + {4'h0, cin};
  wire [8:0] dif9 = {1'b0, acc_reg} - {1'b0, alu_src} - {8'h00, cin};
  wire [4:0] difn = {1'b0, acc_reg[3:0]} - {1'b0, alu_src[3:0]} - {4'h0, cin};
  wire [7:0] alu_res = is_sub ? dif9[7:0] : sum9[7:0];
  wire alu_cy = is_sub ? dif9[8] : sum9[8]; // RULE16
  wire alu_ac = is_sub ? difn[4] : sumn[4];
  wire alu_ov = is_sub ? (acc_reg[7] != alu_src[7]) & (alu_res[7] != acc_reg[7])
    : (acc_reg[7] == alu_src[7]) & (alu_res[7] != acc_reg[7]);
  // increment / decrement of acc, bank register or fetched byte
  wire [7:0] id_base = is_acc_imm ? acc_reg : rn_val;
  wire [7:0] id_res = is_dec ? id_base - 8'h01 : id_base + 8'h01;
  wire [7:0] rmw_res = is_cplbit ? src_mem ^ (8'h01 << code_byte1[2:0])
    : is_dec ? src_mem - 8'h01 : src_mem + 8'h01;
  // multiply, divide, decimal adjust; divide by zero leaves acc and b
  wire [15:0] prod = acc_reg * b_reg;
  wire div_ok = b_reg != 8'h00;
  wire [7:0] quot = div_ok ? acc_reg / b_reg : acc_reg;
  wire [7:0] remd = div_ok ? acc_reg % b_reg : b_reg;
  wire lo_fix = (acc_reg[3:0] > 4'h9) | psw_reg[arith_pkg::PSW_AC];
  wire [8:0] da_t = {1'b0, acc_reg} + (lo_fix ? 9'h006 : 9'h000);
  wire hi_fix = da_t[8] | cy | (da_t[7:4] > 4'h9);
  wire [8:0] da9 = da_t + (hi_fix ? 9'h060 : 9'h000);
  wire sfr_wr = last & rmw & tgt_sfr;
  // ==========================================================
  // next values of accumulator, b, pointer and status word
  always_comb begin
    acc_next = acc_reg;
    b_next = b_reg;
    data_pointer_next = data_pointer_reg;
    psw_next = psw_reg;
    if (last) begin
      if (alu_op) begin
        acc_next = alu_res;
        psw_next[arith_pkg::PSW_CY] = alu_cy; // RULE16
        psw_next[arith_pkg::PSW_AC] = alu_ac;
        psw_next[arith_pkg::PSW_OV] = alu_ov;
      end
      if (id_op & is_acc_imm) acc_next = id_res; // RULE6
      if (is_incdptr) data_pointer_next = data_pointer_reg + 16'h0001; // RULE13
      if (is_mul) begin
        acc_next = prod[7:0]; // RULE14
        b_next = prod[15:8];
        psw_next[arith_pkg::PSW_CY] = 1'b0;
        psw_next[arith_pkg::PSW_OV] = prod[15:8] != 8'h00;
      end
      if (is_div) begin
        acc_next = quot; // RULE15
        b_next = remd;
        psw_next[arith_pkg::PSW_CY] = 1'b0;
        psw_next[arith_pkg::PSW_OV] = !div_ok;
      end
      if (is_daa) begin
        acc_next = da9[7:0]; // RULE15
        psw_next[arith_pkg::PSW_CY] = hi_fix;
      end
      if (is_movc) acc_next = table_data; // RULE4
      if (sfr_wr & hit_acc) acc_next = ram_wdata_reg;
      if (sfr_wr & hit_b) b_next = ram_wdata_reg;
      if (sfr_wr & hit_psw) psw_next = ram_wdata_reg;
      if (sfr_wr & hit_dpl) data_pointer_next[7:0] = ram_wdata_reg;
      if (sfr_wr & hit_dph) data_pointer_next[15:8] = ram_wdata_reg;
    end
    psw_next[0] = ^acc_next; // parity always tracks acc
  end
  // bank file write port: register inc/dec or internal read-modify-write
  wire rf_we = last & ((id_op & is_rn) | (rmw & tgt_bank));
  wire [4:0] rf_idx = is_rn ? rn_idx : tgt[4:0];
  wire [7:0] rf_wd = is_rn ? id_res : ram_wdata_reg;
  // ==========================================================
  // sequencing: fixed per-form cycle count, then pc advances by length
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_reg <= 3'h0;
      pc_reg <= arith_pkg::PC_RST;
      done_reg <= 1'b0;
    end else begin
      cnt_reg <= last ? 3'h0 : cnt_reg + 3'h1; // RULE8
      pc_reg <= last ? pc_reg + nlen : pc_reg;
      done_reg <= last;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      acc_reg <= 8'h00;
      b_reg <= 8'h00;
      data_pointer_reg <= 16'h0000;
      psw_reg <= arith_pkg::PSW_RST;
    end else begin
      acc_reg <= acc_next;
      b_reg <= b_next;
      data_pointer_reg <= data_pointer_next;
      psw_reg <= psw_next;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < 32; i++) bank_reg[i] <= 8'h00;
    end else if (rf_we) begin
      bank_reg[rf_idx] <= rf_wd; // RULE3 RULE13
    end
  end

  // memory port: address at start, data back next cycle, write one later
  always_ff @(posedge clk) begin
    if (srst) begin
      ram_addr_reg <= 8'h00;
      ram_sfr_reg <= 1'b0;
      ram_re_reg <= 1'b0;
      ram_we_reg <= 1'b0;
      ram_wdata_reg <= 8'h00;
      table_addr_reg <= 16'h0000;
    end else begin
      ram_re_reg <= start & mem_op & !tgt_int; // RULE1 RULE2
      ram_we_reg <= (cnt_reg == 3'h1) & rmw & !tgt_int;
      if (start & mem_op) begin
        ram_addr_reg <= tgt;
        ram_sfr_reg <= tgt_sfr;
      end
      if ((cnt_reg == 3'h1) & rmw) ram_wdata_reg <= rmw_res;
      // code-space table read only; data space never indexed
      if (start & is_movc) table_addr_reg <= data_pointer_reg + {8'h00, acc_reg}; // RULE4
    end
  end
  assign code_addr = pc_reg;
  assign table_addr = table_addr_reg;
  assign ram_addr = ram_addr_reg;
  assign ram_sfr = ram_sfr_reg;
  assign ram_re = ram_re_reg;
  assign ram_we = ram_we_reg;
  assign ram_wdata = ram_wdata_reg;
  assign acc_out = acc_reg;
  assign psw_out = psw_reg;
  assign insn_done = done_reg;
  // ==========================================================
  // assertions
  property p_dir_read;
    @(posedge clk) disable iff (srst)
      start & alu_op & is_dir & !tgt_int |=> ram_re && ram_addr == $past(code_byte1) && !insn_done
        ##1 insn_done;
  endproperty
  a_dir_read: assert property (p_dir_read) else $error("direct read wrong"); // RULE1
  property p_ind_read;
    @(posedge clk) disable iff (srst)
      start & alu_op & is_ind & !tgt_int |=> ram_re && !ram_sfr && ram_addr == $past(ri_val);
  endproperty
  a_ind_read: assert property (p_ind_read) else $error("indirect address wrong"); // RULE2
  property p_add_rn;
    @(posedge clk) disable iff (srst)
      start & is_rn & hi == arith_pkg::GRP_ADD |=> insn_done && acc_out == $past(acc_reg + rn_val);
  endproperty
  a_add_rn: assert property (p_add_rn) else $error("add register wrong"); // RULE10
  property p_movc;
    @(posedge clk) disable iff (srst)
      start & is_movc |=> table_addr == $past(data_pointer_reg + {8'h00, acc_reg}) ##4 insn_done;
  endproperty
  a_movc: assert property (p_movc) else $error("indexed read wrong"); // RULE4
  property p_bit;
    @(posedge clk) disable iff (srst)
      start & is_cplbit & !code_byte1[7] |=> ram_addr[7:4] == 4'h2 && !ram_sfr;
  endproperty
  a_bit: assert property (p_bit) else $error("bit byte wrong"); // RULE5
  property p_inc_acc;
    @(posedge clk) disable iff (srst)
      start & op == 8'h04 |=> insn_done && acc_out == $past(acc_reg) + 8'h01;
  endproperty
  a_inc_acc: assert property (p_inc_acc) else $error("acc increment wrong"); // RULE6
  property p_imm;
    @(posedge clk) disable iff (srst)
      start & op == 8'h24 |=> !insn_done
        ##1 insn_done && acc_out == $past(acc_reg, 2) + $past(code_byte1, 2);
  endproperty
  a_imm: assert property (p_imm) else $error("immediate add wrong"); // RULE7
  property p_div;
    @(posedge clk) disable iff (srst)
      start & is_div |=> !insn_done [*5] ##1 insn_done;
  endproperty
  a_div: assert property (p_div) else $error("divide timing wrong"); // RULE15
  property p_mul;
    @(posedge clk) disable iff (srst)
      start & is_mul |=> !insn_done ##1 insn_done && acc_out == $past(prod[7:0], 2);
  endproperty
  a_mul: assert property (p_mul) else $error("multiply wrong"); // RULE14
  property p_inc_dir;
    @(posedge clk) disable iff (srst)
      start & id_op & is_dir & !tgt_int |=> ram_re ##1 ram_we ##1 insn_done;
  endproperty
  a_inc_dir: assert property (p_inc_dir) else $error("direct increment timing"); // RULE13
  property p_carry;
    @(posedge clk) disable iff (srst)
      start & is_rn & is_sub & ({1'b0, acc_reg} < {1'b0, rn_val} + {8'h00, cy}) |=> psw_out[7];
  endproperty
  a_carry: assert property (p_carry) else $error("borrow not set"); // RULE16
  property p_bank;
    @(posedge clk) disable iff (srst)
      start & op[7:3] == 5'h01 |-> ##2 bank_reg[$past(rn_idx, 2)] == $past(rn_val, 2) + 8'h01;
  endproperty
  a_bank: assert property (p_bank) else $error("bank register inc wrong"); // RULE17
  c_div: cover property (@(posedge clk) start & is_div ##6 insn_done);
  c_movc: cover property (@(posedge clk) start & is_movc ##5 insn_done);
  c_rmw: cover property (@(posedge clk) ram_re ##1 ram_we);
endmodule : arith_core

//--- test/code_ram_model.sv
`timescale 1ns/1ps
// ==========================================================
// program memory and data ram facing the arithmetic core
module code_ram_model (
  input wire logic clk,
  input wire logic [15:0] code_addr,
  output logic [7:0] code_byte0,
  output logic [7:0] code_byte1,
  input wire logic [15:0] table_addr,
  output logic [7:0] table_data,
  input wire logic [7:0] ram_addr,
  input wire logic ram_sfr,
  input wire logic ram_re,
  input wire logic ram_we,
  input wire logic [7:0] ram_wdata,
  output logic [7:0] ram_rdata
);
  // only 256 code bytes: upper address bits are ignored
  logic [7:0] code [0:255];
  // ram and sfr space kept apart by the space flag
  logic [7:0] ram [0:511];
  logic [7:0] wr_addr, wr_data, rd_addr, last_q;
  logic wr_sfr, rd_sfr, re_d;
  int n_acc;
  // unknown opcode everywhere, so stray fetches stay harmless
  initial begin
    for (int i = 0; i < 256; i++) begin
      code[i] = 8'hA5;
    end
    for (int i = 0; i < 512; i++) begin
      ram[i] = 8'h00;
    end
    ram[9'h020] = 8'h0F;
    ram[9'h030] = 8'h90;
    ram[9'h180] = 8'h33;
    re_d = 1'b0;
    last_q = 8'h00;
    n_acc = 0;
  end
  assign code_byte0 = code[code_addr[7:0]];
  assign code_byte1 = code[code_addr[7:0] + 8'h01];
  assign table_data = code[table_addr[7:0]];
  // data shown only around the strobe, inverted junk otherwise
  assign ram_rdata = (ram_re || re_d) ? ram[{ram_sfr, ram_addr}] : ~last_q;
  // combinational-read ram with clocked writes and an access log for the bench
  always @(posedge clk) begin
    re_d <= ram_re;
    if (ram_re || re_d) begin
      last_q <= ram[{ram_sfr, ram_addr}];
    end
    if (ram_re || ram_we) begin
      n_acc <= n_acc + 1;
    end
    if (ram_re) begin
      rd_addr <= ram_addr;
      rd_sfr <= ram_sfr;
    end
    if (ram_we) begin
      ram[{ram_sfr, ram_addr}] <= ram_wdata;
      wr_addr <= ram_addr;
      wr_data <= ram_wdata;
      wr_sfr <= ram_sfr;
    end
  end
endmodule : code_ram_model

//--- test/tb_top.sv
`timescale 1ns/1ps
// ==========================================================
// instruction-level bench for the arithmetic core
module tb_top;
  logic clk, srst, ram_sfr, ram_re, ram_we, insn_done, p_cy, p_chk;
  logic [15:0] code_addr, table_addr, p_pc;
  logic [7:0] code_byte0, code_byte1, table_data, ram_addr, ram_wdata, ram_rdata;
  logic [7:0] acc_out, psw_out, p_acc;
  int n_errors, tests_run, wp, p_cyc, n0;

  arith_core dut (
    .clk(clk),
    .srst(srst),
    .code_addr(code_addr),
    .code_byte0(code_byte0),
    .code_byte1(code_byte1),
    .table_addr(table_addr),
    .table_data(table_data),
    .ram_addr(ram_addr),
    .ram_sfr(ram_sfr),
    .ram_re(ram_re),
    .ram_we(ram_we),
    .ram_wdata(ram_wdata),
    .ram_rdata(ram_rdata),
    .acc_out(acc_out),
    .psw_out(psw_out),
    .insn_done(insn_done)
  );
  code_ram_model mdl (
    .clk(clk),
    .code_addr(code_addr),
    .code_byte0(code_byte0),
    .code_byte1(code_byte1),
    .table_addr(table_addr),
    .table_data(table_data),
    .ram_addr(ram_addr),
    .ram_sfr(ram_sfr),
    .ram_re(ram_re),
    .ram_we(ram_we),
    .ram_wdata(ram_wdata),
    .ram_rdata(ram_rdata)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ==========================================================
  // reporting
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out

  // ==========================================================
  // instruction stepping
  // no stall input: the next instruction is loaded while the previous one
  // runs, and the previous one is judged when its done pulse shows up
  task automatic step(input logic [7:0] b0, input logic [7:0] b1, input int len,
                      input int cyc, input logic [7:0] a, input logic c);
    int k;
    k = 0;
    mdl.code[wp[7:0]] = b0;
    mdl.code[wp[7:0] + 8'h01] = b1;
    wp = wp + len;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (insn_done !== 1'b1 && k < 40);
    if (p_chk) begin
      check(16'(k), 16'(p_cyc));
      check(code_addr, p_pc);
      check(16'(acc_out), 16'(p_acc));
      check(16'({psw_out[7], psw_out[0]}), 16'({p_cy, ^p_acc}));
    end
    p_chk = 1'b1;
    p_cyc = cyc;
    p_acc = a;
    p_cy = c;
    p_pc = 16'(wp);
  endtask : step

  // ==========================================================
  // scenarios
  task automatic t_reset;
    // reset already high from time zero; six edges see it high in all
    repeat (5) @(posedge clk);
    #1;
    check(code_addr, 16'h0000);
    check(16'({acc_out, psw_out}), 16'h0000);
    check(16'({insn_done, ram_re, ram_we}), 16'h0000);
    @(posedge clk);
    srst <= 1'b0;
    #1;
    $display("reset test done");
  endtask : t_reset

  task automatic t_add;
    step(8'h24, 8'h7F, 2, 2, 8'h7F, 1'b0);
    step(8'h25, 8'h30, 2, 2, 8'h0F, 1'b1);
    step(8'h28, 8'hA5, 1, 1, 8'h0F, 1'b0);
    check(16'({mdl.rd_sfr, mdl.rd_addr}), 16'h0030);
    $display("add test done");
  endtask : t_add

  task automatic t_sum_with_carry_to_acc;
    step(8'h24, 8'hF1, 2, 2, 8'h00, 1'b1);
    step(8'h34, 8'h05, 2, 2, 8'h06, 1'b0);
    step(8'h38, 8'hA5, 1, 1, 8'h06, 1'b0);
    step(8'h36, 8'hA5, 1, 2, 8'h06, 1'b0);
    $display("add with carry test done");
  endtask : t_sum_with_carry_to_acc

  task automatic t_minus_with_borrow;
    step(8'h94, 8'h07, 2, 2, 8'hFF, 1'b1);
    step(8'h98, 8'hA5, 1, 1, 8'hFE, 1'b0);
    step(8'h95, 8'h30, 2, 2, 8'h6E, 1'b0);
    step(8'h96, 8'hA5, 1, 2, 8'h6E, 1'b0);
    $display("minus_with_borrow test done");
  endtask : t_minus_with_borrow

  // bank pointer 0 is bumped to 1 so the indirect form lands on bank reg 1
  task automatic t_incdec;
    n0 = mdl.n_acc;
    step(8'h04, 8'hA5, 1, 1, 8'h6F, 1'b0);
    step(8'h14, 8'hA5, 1, 1, 8'h6E, 1'b0);
    step(8'h08, 8'hA5, 1, 2, 8'h6E, 1'b0);
    step(8'h06, 8'hA5, 1, 3, 8'h6E, 1'b0);
    step(8'h29, 8'hA5, 1, 1, 8'h6F, 1'b0);
    check(16'(mdl.n_acc), 16'(n0));
    step(8'h05, 8'h30, 2, 3, 8'h6F, 1'b0);
    step(8'h15, 8'h30, 2, 3, 8'h6F, 1'b0);
    step(8'hA3, 8'hA5, 1, 1, 8'h6F, 1'b0);
    check({mdl.wr_addr, mdl.wr_data}, 16'h3090);
    check(16'(mdl.n_acc), 16'(n0 + 4));
    $display("increment test done");
  endtask : t_incdec

  // data_pointer is 1 here, accumulator 6F
  task automatic t_table;
    mdl.code[8'h70] = 8'h5A;
    step(8'h93, 8'hA5, 1, 5, 8'h5A, 1'b0);
    step(8'h05, 8'hF0, 2, 3, 8'h5A, 1'b0);
    check(table_addr, 16'h0070);
    $display("table test done");
  endtask : t_table

  // register b assumed cleared by reset, bumped to 1 in t_table, then to 2
  task automatic t_muldiv;
    step(8'h05, 8'hF0, 2, 3, 8'h5A, 1'b0);
    step(8'hA4, 8'hA5, 1, 2, 8'hB4, 1'b0);
    step(8'h84, 8'hA5, 1, 6, 8'hB4, 1'b0);
    check(16'(psw_out[2]), 16'h0000);
    step(8'hD4, 8'hA5, 1, 3, 8'h14, 1'b1);
    check(16'(psw_out[2]), 16'h0001);
    $display("product and divide test done");
  endtask : t_muldiv

  task automatic t_bit;
    step(8'hB2, 8'h05, 2, 3, 8'h14, 1'b1);
    step(8'hB2, 8'h87, 2, 3, 8'h14, 1'b1);
    check({mdl.wr_addr, mdl.wr_data}, 16'h202F);
    step(8'hA5, 8'hA5, 1, 1, 8'h14, 1'b1);
    check({mdl.wr_addr, mdl.wr_data}, 16'h80B3);
    check(16'(mdl.wr_sfr), 16'h0001);
    step(8'hA5, 8'hA5, 1, 1, 8'h14, 1'b1);
    $display("bit test done");
  endtask : t_bit

  // ==========================================================
  // main sequence and watchdog
  initial begin
    srst = 1'b1;
    wp = 1;
    p_chk = 1'b0;
    n_errors = 0;
    tests_run = 0;
    t_reset;
    t_add;
    t_sum_with_carry_to_acc;
    t_minus_with_borrow;
    t_incdec;
    t_table;
    t_muldiv;
    t_bit;
    close_out;
  end

  // the run needs some 70 cycles; this allows about seventy times that
  initial begin
    #20000;
    n_errors++;
    close_out;
  end
endmodule : tb_top
